// ===== hw/ced_exc_map.vh
/*
 constants for the exception and debug checking unit.
 assumes: included by hw/ced_exc_unit.v only.
*/
`ifndef CED_EXC_MAP_VH
`define CED_EXC_MAP_VH
// ==========================================
// fault vectors
`define CED_VEC_DIVIDE 8'h00
`define CED_VEC_INVOP 8'h06
`define CED_VEC_GPROT 8'h0d
`define CED_VEC_PAGE 8'h0e
`define CED_VEC_ALIGN 8'h11
`define CED_VEC_MCHK 8'h12
`define CED_VEC_SIMD 8'h13
// ==========================================
// register offsets
`define CED_OFS_FEATURE 4'h0
`define CED_OFS_BPCTRL 4'h1
`define CED_OFS_DBGSTAT 4'h2
`define CED_OFS_SIMDCS 4'h3
`define CED_OFS_PDBASE 4'h4
`define CED_OFS_STATUS 4'h5
`define CED_OFS_ALIAS_A 4'h6
`define CED_OFS_ALIAS_B 4'h7
// ==========================================
// feature control bits and writable mask
`define CED_FEAT_DBGEXT 3
`define CED_FEAT_MCE 6
`define CED_FEAT_WMASK 32'h000007ff
// ==========================================
// breakpoint control layout
`define CED_BP_RSVD_MASK 32'h0000d800
`define CED_BP_TYPE_LSB 5'h10
`define CED_BP_FIELD_STEP 4
`define CED_BP_EXEC 2'h0
`define CED_BP_WRITE 2'h1
`define CED_BP_IO 2'h2
`define CED_BP_RDWR 2'h3
// ==========================================
// debug status and simd control layout
`define CED_DS_RSVD_BIT 12
`define CED_DS_RSVD_VAL 1'h0
`define CED_DS_RESET 32'hffff0ff0
`define CED_SIMD_RESET 32'h00001f80
`define CED_SIMD_FLAGS 32'h0000003f
// ==========================================
// decoder limits and divide extremes
`define CED_MAX_ILEN 5'h0f
`define CED_NEG8 8'h80
`define CED_NEG16 16'h8000
`endif

// ===== hw/ced_exc_unit.v
/*
 exception-condition and debug-register checking unit: decides faults,
 holds debug and feature registers, presents one vector at a time.
 assumes: pipeline condition inputs are on ref_clk and hold for one cycle;
 register port is the plain strobe port on the same clock.
*/
// Behaviour
// - access type 00 breaks on execution only, 01 on data writes only.
// - type 10 breaks on io when debug extensions on; 11 on data read/write.
// - breakpoint control bits 11, 12, 14, 15 always read zero.
// - debug status bit 12 ignores written ones, keeps fixed value.
// - debug extensions off: legacy 4 and 5 alias status and control.
// - debug extensions on: legacy 4 or 5 access raises invalid opcode.
// - moves to or from old test registers raise invalid opcode.
// - simd fp exception raises vector 19 and records flags.
// - hardware error raises vector 18 only if machine-check enabled.
// - writing one to reserved special register bit raises vector 13.
// - reserved bit set in paging entry raises page fault vector 14.
// - unaligned reference with alignment checking raises vector 17.
// - divide fault vector 0 reports failing instruction pointer.
// - most negative signed quotient is returned, no divide fault.
// - improper bus-lock prefix raises invalid opcode vector 6.
// - instruction longer than 15 bytes raises general protection.
// - task switch to 16-bit task leaves page directory base unchanged.
// - pending faults served: trap, interrupt, fetch, decode, execute.
`timescale 1ns/1ps
`include "ced_exc_map.vh"
module ced_exc_unit (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// register port
	input wire [3:0] regAddr,
	input wire [31:0] regWrData,
	input wire regWrStb,
	input wire regRdStb,
	output reg [31:0] regRdData,
	// traps and interrupts, category order of service
	input wire trapPrev,
	input wire [7:0] trapVector,
	input wire extIntr,
	input wire [7:0] extVector,
	// fetch and decode conditions
	input wire fetchPageRsvd,
	input wire [4:0] instLength,
	input wire lockMisuse,
	input wire testRegMove,
	// execution conditions
	input wire hwError,
	input wire alignCheckOn,
	input wire unalignedRef,
	input wire pageEntryRsvd,
	input wire simdException,
	input wire [5:0] simdFlags,
	// divide result
	input wire divIssue,
	input wire divSigned,
	input wire divWord,
	input wire divZero,
	input wire [31:0] divQuotient,
	// pointers and task switch
	input wire [31:0] instPointer,
	input wire [31:0] nextPointer,
	input wire taskSwitch,
	input wire task32,
	input wire [31:0] taskPageBase,
	// breakpoint match request
	input wire [1:0] bpSlot,
	input wire bpExec,
	input wire bpDataRd,
	input wire bpDataWr,
	input wire bpIo,
	// fault delivery
	output reg faultValid,
	output reg [7:0] faultVector,
	output reg [31:0] savedCodePointer,
	output reg bpHit
);
	// ==========================================
	// reset release
	// async assert, release after two edges
	reg rstMeta_reg;
	reg rstSync_reg;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rstMeta_reg <= 1'b0;
			rstSync_reg <= 1'b0;
		end else begin
			rstMeta_reg <= 1'b1;
			rstSync_reg <= rstMeta_reg;
		end
	end
	wire rstN = rstSync_reg;

	// ==========================================
	// registers
	reg [31:0] featureCtrl_reg;
	reg [31:0] bpCtrl_reg;
	reg [31:0] dbgStatus_reg;
	reg [31:0] simdCs_reg;
	reg [31:0] pageDirBase_reg;

	// ==========================================
	// feature enables
	wire dbgExtOn = featureCtrl_reg[`CED_FEAT_DBGEXT];
	wire mceOn = featureCtrl_reg[`CED_FEAT_MCE];

	// resolve legacy alias onto real offset
	function [3:0] aliasOfs;
		input [3:0] a;
		begin
			if (a == `CED_OFS_ALIAS_A)
				aliasOfs = `CED_OFS_DBGSTAT;
			else if (a == `CED_OFS_ALIAS_B)
				aliasOfs = `CED_OFS_BPCTRL;
			else
				aliasOfs = a;
		end
	endfunction

	wire isAlias = (regAddr == `CED_OFS_ALIAS_A) || (regAddr == `CED_OFS_ALIAS_B);
	wire aliasTrap = isAlias && dbgExtOn && (regWrStb || regRdStb);
	wire [3:0] effAddr = aliasOfs(regAddr);
	wire wrOk = regWrStb && !aliasTrap;

	// ==========================================
	// write decode, one enable per register
	wire wrFeat = wrOk && (effAddr == `CED_OFS_FEATURE);
	wire wrBp = wrOk && (effAddr == `CED_OFS_BPCTRL);
	wire wrDs = wrOk && (effAddr == `CED_OFS_DBGSTAT);
	wire wrSimd = wrOk && (effAddr == `CED_OFS_SIMDCS);
	wire wrPd = wrOk && (effAddr == `CED_OFS_PDBASE);
	wire featRsvdWr = wrFeat && ((regWrData & ~`CED_FEAT_WMASK) != 32'h0);
	wire [31:0] simdBase = wrSimd ? regWrData : simdCs_reg;

	// ==========================================
	// register writes and state
	always @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			featureCtrl_reg <= 32'h0;
			bpCtrl_reg <= 32'h0;
			dbgStatus_reg <= `CED_DS_RESET;
			simdCs_reg <= `CED_SIMD_RESET;
			pageDirBase_reg <= 32'h0;
		end else begin
			if (wrFeat && !featRsvdWr)
				featureCtrl_reg <= regWrData;
			if (wrBp)
				bpCtrl_reg <= regWrData & ~`CED_BP_RSVD_MASK;
			if (wrDs) begin
				dbgStatus_reg <= regWrData;
				dbgStatus_reg[`CED_DS_RSVD_BIT] <= `CED_DS_RSVD_VAL;
			end
			// hardware flag set is ORed into a same-cycle software write
			if (simdException)
				simdCs_reg <= simdBase | {26'h0, simdFlags};
			else if (wrSimd)
				simdCs_reg <= regWrData;
			if (taskSwitch && task32)
				pageDirBase_reg <= taskPageBase;
			else if (wrPd)
				pageDirBase_reg <= regWrData;
		end
	end

	// ==========================================
	// read port, data stand one cycle, zero otherwise
	wire rdOk = regRdStb && !aliasTrap;
	wire [31:0] statusWord = {24'h0, faultVector};
	reg [31:0] rdMux;
	always @* begin
		case (effAddr)
			`CED_OFS_FEATURE: rdMux = featureCtrl_reg;
			`CED_OFS_BPCTRL: rdMux = bpCtrl_reg & ~`CED_BP_RSVD_MASK;
			`CED_OFS_DBGSTAT: rdMux = dbgStatus_reg;
			`CED_OFS_SIMDCS: rdMux = simdCs_reg;
			`CED_OFS_PDBASE: rdMux = pageDirBase_reg;
			`CED_OFS_STATUS: rdMux = statusWord;
			default: rdMux = 32'h0;
		endcase
	end
	always @(posedge ref_clk or negedge rstN) begin
		if (!rstN)
			regRdData <= 32'h0;
		else if (rdOk)
			regRdData <= rdMux;
		else
			regRdData <= 32'h0;
	end

	// ==========================================
	// breakpoint type decode
	function [1:0] bpTypeOf;
		input [31:0] ctl;
		input [1:0] slot;
		reg [4:0] pos;
		begin
			pos = 5'h0;
			pos = `CED_BP_TYPE_LSB + {1'b0, slot, 2'h0};
			bpTypeOf = ctl[pos +: 2];
		end
	endfunction
	wire [1:0] bpType = bpTypeOf(bpCtrl_reg, bpSlot);

	// ==========================================
	// breakpoint match by access type
	reg bpMatch;
	always @* begin
		case (bpType)
			`CED_BP_EXEC: bpMatch = bpExec;
			`CED_BP_WRITE: bpMatch = bpDataWr;
			`CED_BP_IO: bpMatch = dbgExtOn && bpIo;
			`CED_BP_RDWR: bpMatch = bpDataRd || bpDataWr;
			default: bpMatch = 1'b0;
		endcase
	end

	// ==========================================
	// divide check
	reg quotFits;
	always @* begin
		quotFits = 1'b0;
		if (divWord) begin
			if (divSigned)
				quotFits = (divQuotient[31:15] == 17'h0) || (divQuotient[31:15] == 17'h1ffff);
			else
				quotFits = (divQuotient[31:16] == 16'h0);
		end else begin
			if (divSigned)
				quotFits = (divQuotient[31:7] == 25'h0) || (divQuotient[31:7] == 25'h1ffffff);
			else
				quotFits = (divQuotient[31:8] == 24'h0);
		end
	end
	// most negative quotient stands; its positive twin overflows
	wire quotMostNeg = divWord ? (divQuotient == {16'hffff, `CED_NEG16}) :
		(divQuotient == {24'hffffff, `CED_NEG8});
	wire divFault = divIssue && (divZero || !(quotFits || (divSigned && quotMostNeg)));

	// ==========================================
	// fault selection by category
	// decode category
	wire ilenOver = instLength > `CED_MAX_ILEN;
	wire decUd = lockMisuse || testRegMove || aliasTrap;
	wire decGp = ilenOver || featRsvdWr;

	// execution category
	wire mchkFault = hwError && mceOn;
	wire alignFault = alignCheckOn && unalignedRef;

	reg selValid;
	reg [7:0] selVector;
	reg selAtInst;
	always @* begin
		selValid = 1'b1;
		selAtInst = 1'b1;
		selVector = 8'h0;
		if (trapPrev) begin
			selVector = trapVector;
			selAtInst = 1'b0;
		end else if (extIntr) begin
			selVector = extVector;
		end else if (fetchPageRsvd) begin
			selVector = `CED_VEC_PAGE;
		end else if (decUd) begin
			selVector = `CED_VEC_INVOP;
		end else if (decGp) begin
			selVector = `CED_VEC_GPROT;
		end else if (mchkFault) begin
			selVector = `CED_VEC_MCHK;
		end else if (divFault) begin
			selVector = `CED_VEC_DIVIDE;
		end else if (pageEntryRsvd) begin
			selVector = `CED_VEC_PAGE;
		end else if (alignFault) begin
			selVector = `CED_VEC_ALIGN;
		end else if (simdException) begin
			selVector = `CED_VEC_SIMD;
		end else begin
			selValid = 1'b0;
		end
	end

	// ==========================================
	// delivery
	// vector and pointer hold until the next fault
	always @(posedge ref_clk or negedge rstN) begin
		if (!rstN) begin
			faultValid <= 1'b0;
			faultVector <= 8'h0;
			savedCodePointer <= 32'h0;
			bpHit <= 1'b0;
		end else begin
			faultValid <= selValid;
			bpHit <= bpMatch;
			if (selValid) begin
				faultVector <= selVector;
				savedCodePointer <= selAtInst ? instPointer : nextPointer;
			end
		end
	end
endmodule // ced_exc_unit

// ===== bench/ced_exc_props_properties.sv
/* checker: fault vector and register read properties
 assumes: bound to ced_exc_unit, one clock domain */
`timescale 1ns/1ps
module ced_exc_props (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// register port
	input wire [3:0] regAddr,
	input wire regWrStb,
	input wire regRdStb,
	input wire [31:0] regRdData,
	// pipeline conditions
	input wire trapPrev,
	input wire [7:0] trapVector,
	input wire extIntr,
	input wire fetchPageRsvd,
	input wire [4:0] instLength,
	input wire lockMisuse,
	input wire testRegMove,
	input wire hwError,
	input wire alignCheckOn,
	input wire unalignedRef,
	input wire pageEntryRsvd,
	input wire simdException,
	input wire divIssue,
	input wire divSigned,
	input wire divWord,
	input wire divZero,
	input wire [31:0] divQuotient,
	input wire [31:0] instPointer,
	// fault delivery
	input wire faultValid,
	input wire [7:0] faultVector,
	input wire [31:0] savedCodePointer
);
	// ==========================================
	// priority helpers
	wire hi = trapPrev | extIntr;
	// register access that may raise a decode fault
	wire regAcc = ((regWrStb | regRdStb) & (regAddr[3:1] == 3'h3))
		| (regWrStb & (regAddr == 4'h0));
	wire dec = hi | fetchPageRsvd | lockMisuse | testRegMove | regAcc | (instLength > 5'h0f);
	wire q = !dec && !hwError;
	wire pre = q && !divIssue && !pageEntryRsvd;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_trap; trapPrev |=> faultValid && faultVector == $past(trapVector); endproperty
	a_trap: assert property (p_trap) else $error("trap vector wrong");
	property p_fetch; fetchPageRsvd && !hi |=> faultValid && faultVector == 8'h0e; endproperty
	a_fetch: assert property (p_fetch) else $error("page fault vector wrong");
	property p_inv; (lockMisuse | testRegMove) && !hi && !fetchPageRsvd |=> faultVector == 8'h06;
	endproperty
	a_inv: assert property (p_inv) else $error("invalid opcode vector wrong");
	property p_div; divIssue && divZero && q |=> faultVector == 8'h00
		&& savedCodePointer == $past(instPointer); endproperty
	a_div: assert property (p_div) else $error("divide fault wrong");
	property p_neg; divIssue && divSigned && !divZero && !divWord && divQuotient == 32'hffffff80
		&& q && !pageEntryRsvd && !unalignedRef && !simdException |=> !faultValid; endproperty
	a_neg: assert property (p_neg) else $error("negative quotient faulted");
	property p_align; alignCheckOn && unalignedRef && pre |=> faultVector == 8'h11; endproperty
	a_align: assert property (p_align) else $error("alignment vector wrong");
	property p_simd; simdException && pre && !(alignCheckOn && unalignedRef)
		|=> faultValid && faultVector == 8'h13; endproperty
	a_simd: assert property (p_simd) else $error("simd vector wrong");
	property p_bprd; regRdStb && regAddr == 4'h1 |=> (regRdData & 32'h0000d800) == 32'h0; endproperty
	a_bprd: assert property (p_bprd) else $error("breakpoint reserved bit set");
	property p_dsrd; regRdStb && regAddr == 4'h2 |=> !regRdData[12]; endproperty
	a_dsrd: assert property (p_dsrd) else $error("status bit 12 set");
	property p_dpos; divIssue && divSigned && !divZero && divWord && divQuotient == 32'h00008000
		&& q |=> faultValid && faultVector == 8'h00; endproperty
	a_dpos: assert property (p_dpos) else $error("positive overflow not faulted");
	property p_ilen; instLength > 5'h0f && !hi && !fetchPageRsvd && !lockMisuse && !testRegMove
		&& !regAcc |=> faultValid && faultVector == 8'h0d; endproperty
	a_ilen: assert property (p_ilen) else $error("length limit not enforced");
	cover property (faultValid && faultVector == 8'h12);
	cover property (faultValid && faultVector == 8'h00);
	cover property (regRdStb && regAddr == 4'h6);
endmodule // ced_exc_props
bind ced_exc_unit ced_exc_props u_props (.*);

// ===== bench/ced_pipe_model.sv
/* pipeline model: one set of condition pulses per request
 assumes: bench raises fire for one cycle beside req */
`timescale 1ns/1ps
module ced_pipe_model (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// request from bench
	input wire fire,
	input wire [12:0] req,
	// conditions and pointer to the unit
	output reg [12:0] cond,
	output reg [31:0] ip
);
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			cond <= 13'h0;
			ip <= 32'h0;
		end else begin
			cond <= fire ? req : 13'h0;
			if (fire)
				ip <= ip + 32'h4;
		end
	end
endmodule // ced_pipe_model

// ===== bench/tb_top.sv
/* bench: register, breakpoint and fault scenarios
 assumes: ced_exc_unit, ced_pipe_model, bound checker */
`timescale 1ns/1ps
module tb_top;
	reg ref_clk = 0, nrst = 0, ws = 0, rs = 0, fire = 0;
	reg [3:0] ra = 0;
	reg [31:0] wd = 0, dq = 0, pb = 0;
	reg [12:0] req = 0;
	reg [8:0] mx = 0;
	reg [7:0] tv = 8'h03, ev = 8'h20;
	reg [5:0] sf = 0;
	reg [4:0] il = 5'h0f;
	wire [31:0] rdat, scp, ip;
	wire [12:0] c;
	wire [7:0] vec;
	wire fv, bh;
	integer bad_count = 0, n_checks = 0, cyc = 0, i;
	localparam [83:0] BT = 84'h213_007_20b_005_212_010_204;
	always #25 ref_clk = ~ref_clk;
	// ==========================================
	// model and unit
	ced_pipe_model u_pm (.ref_clk, .nrst, .fire, .req, .cond(c), .ip);
	ced_exc_unit u_dut (.ref_clk, .nrst, .regAddr(ra), .regWrData(wd), .regWrStb(ws),
		.regRdStb(rs), .regRdData(rdat), .trapPrev(c[0]), .trapVector(tv), .extIntr(c[1]),
		.extVector(ev), .fetchPageRsvd(c[2]), .instLength(il), .lockMisuse(c[3]),
		.testRegMove(c[4]), .hwError(c[5]), .alignCheckOn(c[6]), .unalignedRef(c[7]),
		.pageEntryRsvd(c[8]), .simdException(c[9]), .simdFlags(sf), .divIssue(c[10]),
		.divSigned(c[11]), .divWord(mx[6]), .divZero(c[12]), .divQuotient(dq),
		.instPointer(ip), .nextPointer(ip + 32'h2), .taskSwitch(mx[7]), .task32(mx[8]),
		.taskPageBase(pb), .bpSlot(mx[1:0]), .bpExec(mx[2]), .bpDataRd(mx[3]),
		.bpDataWr(mx[4]), .bpIo(mx[5]), .faultValid(fv), .faultVector(vec),
		.savedCodePointer(scp), .bpHit(bh));
	// ==========================================
	// tasks
	task chk(input [31:0] g, input [31:0] e);
		begin
			n_checks = n_checks + 1;
			if (g !== e) begin
				bad_count = bad_count + 1;
				$display("mismatch t=%0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge ref_clk);
			ra <= a;
			wd <= d;
			ws <= 1'h1;
			@(posedge ref_clk);
			ws <= 1'h0;
		end
	endtask
	task rdc(input [3:0] a, input [31:0] e, input [31:0] m);
		begin
			@(posedge ref_clk);
			ra <= a;
			rs <= 1'h1;
			@(posedge ref_clk);
			rs <= 1'h0;
			#1 chk(rdat & m, e);
		end
	endtask
	task pp(input [12:0] r, input [8:0] e);
		begin
			@(posedge ref_clk);
			fire <= 1'h1;
			req <= r;
			@(posedge ref_clk);
			fire <= 1'h0;
			@(posedge ref_clk);
			#1 chk(fv ? {fv, vec} : 9'h0, e);
		end
	endtask
	task bp(input [8:0] m, input [31:0] e);
		begin
			@(posedge ref_clk);
			mx <= m;
			@(posedge ref_clk);
			mx <= 9'h0;
			#1 chk(bh, e);
		end
	endtask
	task summarize;
		begin
			$display("checks %0d mismatches %0d", n_checks, bad_count);
			if (bad_count == 0 && n_checks > 0)
				$display("*** PASS ***");
			else
				$display("*** FAIL ***");
			$finish;
		end
	endtask
	always @(posedge ref_clk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			bad_count = bad_count + 1;
			summarize;
		end
	end
	// ==========================================
	// sequence
	initial begin
		repeat (6) @(posedge ref_clk);
		nrst <= 1'h1;
		repeat (5) @(posedge ref_clk);
		rdc(4'h2, 32'hffff0ff0, 32'hffffffff);
		rdc(4'h3, 32'h00001f80, 32'hffffffff);
		pp(13'h0020, 9'h0);
		wr(4'h1, 32'hffffffff);
		rdc(4'h1, 32'hffff27ff, 32'hffffffff);
		wr(4'h2, 32'hffffffff);
		rdc(4'h2, 32'hffffefff, 32'hffffffff);
		rdc(4'h7, 32'hffff27ff, 32'hffffffff);
		rdc(4'h6, 32'hffffefff, 32'hffffffff);
		wr(4'h7, 32'h312000ff);
		rdc(4'h1, 32'h312000ff, 32'hffffffff);
		$display("register test done");
		for (i = 0; i < 7; i = i + 1)
			bp(BT[i*12 +: 9], BT[i*12+9]);
		wr(4'h0, 32'h00000008);
		bp(9'h021, 32'h1);
		rdc(4'h6, 32'h0, 32'hffffffff);
		chk({fv, vec}, 9'h106);
		wr(4'h0, 32'h00000808);
		#1 chk({fv, vec}, 9'h10d);
		rdc(4'h0, 32'h00000008, 32'hffffffff);
		$display("debug test done");
		wr(4'h0, 32'h00000048);
		pp(13'h0020, 9'h112);
		pp(13'h0007, 9'h103);
		chk(scp, ip + 32'h2);
		pp(13'h0006, 9'h120);
		pp(13'h0104, 9'h10e);
		pp(13'h0108, 9'h106);
		pp(13'h0010, 9'h106);
		il <= 5'h10;
		pp(13'h0000, 9'h10d);
		il <= 5'h0f;
		pp(13'h01c0, 9'h10e);
		pp(13'h02c0, 9'h111);
		pp(13'h0080, 9'h0);
		sf <= 6'h05;
		pp(13'h0200, 9'h113);
		rdc(4'h3, 32'h00001f85, 32'hffffffff);
		pp(13'h1400, 9'h100);
		chk(scp, ip);
		dq <= 32'hffffff80;
		pp(13'h0c00, 9'h0);
		dq <= 32'hffff8000;
		mx <= 9'h040;
		pp(13'h0c00, 9'h0);
		dq <= 32'h00008000;
		pp(13'h0c00, 9'h100);
		dq <= 32'h00000080;
		mx <= 9'h000;
		pp(13'h0c00, 9'h100);
		wr(4'h4, 32'h00001000);
		pb <= 32'h00005000;
		bp(9'h080, 32'h0);
		rdc(4'h4, 32'h00001000, 32'hffffffff);
		bp(9'h180, 32'h0);
		rdc(4'h4, 32'h00005000, 32'hffffffff);
		$display("fault test done");
		summarize;
	end
endmodule // tb_top
